/* File: hdl/dmc_regmap.sv */
// Register map and serial frame decoder of a 20-bit voltage-output converter.
// Assumes the serial clock runs at most a tenth of mclk so that pin edges are seen.
//
// Notes on behaviour
// - Address 001 holds the 20-bit output code; writable and readable.
// - Address 010 holds mode fields at bits 1 to 9; bits 0, 10-19 unused.
// - Amp select 0 powers internal amp, feedback resistors in series.
// - Amp select 1 powers internal amp down, feedback resistors in parallel.
// - Ground clamp 0 removes the clamp; the tristate bit then decides the converter mode.
// - Ground clamp 1 clamps output to ground and tristates the converter.
// - Any reset leaves ground clamp and tristate set.
// - While clamped, the tristate bit is ignored; output stays tristated.
// - Top bit 0 writes, 1 reads; address 000 does nothing.
// - Tristate bit 0 gives normal mode, 1 (default) tristates output.
// - Code format bit picks two's complement or offset binary coding.
// - Serial output disable 1 keeps the serial data pin undriven.
`timescale 1ns/10ps
`default_nettype none

module dmc_regmap (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic sync_n,
   input wire logic sclk,
   input wire logic sdin,
   input wire logic reset_pin_n,
   output logic serial_data_out,
   output logic serial_data_out_oe,
   output logic [dmc_pkg::DMC_DATA_BITS-1:0] output_code,
   output logic internal_amp_on,
   output logic feedback_parallel,
   output logic ground_clamp_on,
   output logic dac_tristated,
   output logic code_format,
   output logic [3:0] lin_comp
);
   import dmc_pkg::*;

   typedef struct packed {
      dmc_phase_e phase;
      logic sync_n_prev;
      logic sclk_prev;
      logic [4:0] bit_count;
      logic [23:0] shift_in;
      logic [23:0] shift_out;
      logic [23:0] readback;
      logic [19:0] code;
      logic amp_select;
      logic ground_clamp;
      logic output_tristate;
      logic code_format;
      logic serial_out_disable;
      logic [3:0] lin_comp;
      logic ser_bit;
      logic ser_oe;
      logic out_amp_on;
      logic out_fb_parallel;
      logic out_clamp;
      logic out_tri;
   } dmc_state_s;

   dmc_state_s st;
   dmc_state_s next_st;
   logic sync_n_s;
   logic sclk_s;
   logic sdin_s;
   logic rst_pin_n_s;
   logic sclk_fall;
   logic frame_end;
   logic frame_ok;
   logic op_read;
   logic [2:0] op_addr;
   logic wr_code;
   logic wr_ctrl;
   logic rd_any;

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   dmc_pin_sync #(.INIT(1'h1)) u_sync_n (
      .mclk(mclk), .reset(reset), .ce(ce), .pin(sync_n), .level(sync_n_s));
   dmc_pin_sync #(.INIT(1'h0)) u_sclk (
      .mclk(mclk), .reset(reset), .ce(ce), .pin(sclk), .level(sclk_s));
   dmc_pin_sync #(.INIT(1'h0)) u_sdin (
      .mclk(mclk), .reset(reset), .ce(ce), .pin(sdin), .level(sdin_s));
   dmc_pin_sync #(.INIT(1'h1)) u_rst_pin (
      .mclk(mclk), .reset(reset), .ce(ce), .pin(reset_pin_n), .level(rst_pin_n_s));

   // Mode control word as it reads back; unused positions are zero.
   function automatic logic [19:0] ctrl_word(input dmc_state_s s);
      logic [19:0] w;
      w = 20'h00000;
      w[DMC_AMP_POS] = s.amp_select;
      w[DMC_CLAMP_POS] = s.ground_clamp;
      w[DMC_TRI_POS] = s.output_tristate;
      w[DMC_FMT_POS] = s.code_format;
      w[DMC_SOD_POS] = s.serial_out_disable;
      w[DMC_LIN_HI:DMC_LIN_LO] = s.lin_comp;
      return w;
   endfunction : ctrl_word

   // ***************************************************************
   // Frame decode
   // ***************************************************************
   // A frame counts only with exactly 24 falling clock edges; anything else is dropped.
   always_comb begin
      sclk_fall = st.sclk_prev & ~sclk_s;
      frame_end = (st.phase == DMC_PH_FRAME) & sync_n_s & ~st.sync_n_prev;
      frame_ok = frame_end & (st.bit_count == DMC_FRAME_COUNT);
      op_read = st.shift_in[DMC_OP_POS];
      op_addr = st.shift_in[DMC_ADDR_HI:DMC_ADDR_LO];
      wr_code = frame_ok & (op_read == DMC_OP_WRITE) & (op_addr == DMC_ADDR_CODE);
      wr_ctrl = frame_ok & (op_read == DMC_OP_WRITE) & (op_addr == DMC_ADDR_CTRL);
      rd_any = frame_ok & (op_read == DMC_OP_READ)
         & ((op_addr == DMC_ADDR_CODE) | (op_addr == DMC_ADDR_CTRL));
   end

   // ***************************************************************
   // Next state
   // ***************************************************************
   // Serial port sequencing, register writes and derived output levels.
   always_comb begin
      next_st = st;
      next_st.sync_n_prev = sync_n_s;
      next_st.sclk_prev = sclk_s;
      case (st.phase)
         DMC_PH_IDLE: begin
            if (~sync_n_s & st.sync_n_prev) begin
               // A pending readback word goes out during this frame.
               next_st.phase = DMC_PH_FRAME;
               next_st.bit_count = 5'h00;
               next_st.shift_out = {st.readback[22:0], 1'b0};
               next_st.readback = 24'h000000;
               next_st.ser_bit = st.readback[23];
               next_st.ser_oe = ~st.serial_out_disable;
            end
         end
         DMC_PH_FRAME: begin
            if (frame_end) begin
               next_st.phase = DMC_PH_IDLE;
               next_st.ser_oe = 1'b0;
            end else if (sclk_fall) begin
               // Host samples on the falling edge, so the next bit follows it.
               next_st.shift_in = {st.shift_in[22:0], sdin_s};
               if (st.bit_count != DMC_COUNT_SAT) begin
                  next_st.bit_count = st.bit_count + 5'h01;
               end
               next_st.ser_bit = st.shift_out[23];
               next_st.shift_out = {st.shift_out[22:0], 1'b0};
            end
         end
         default: begin
            next_st.phase = DMC_PH_IDLE;
         end
      endcase
      if (wr_code) begin
         next_st.code = st.shift_in[19:0];
      end
      if (wr_ctrl) begin
         next_st.amp_select = st.shift_in[DMC_AMP_POS];
         next_st.ground_clamp = st.shift_in[DMC_CLAMP_POS];
         next_st.output_tristate = st.shift_in[DMC_TRI_POS];
         next_st.code_format = st.shift_in[DMC_FMT_POS];
         next_st.serial_out_disable = st.shift_in[DMC_SOD_POS];
         next_st.lin_comp = st.shift_in[DMC_LIN_HI:DMC_LIN_LO];
      end
      if (rd_any) begin
         next_st.readback = {st.shift_in[23:20],
            (op_addr == DMC_ADDR_CODE) ? st.code : ctrl_word(st)};
      end
      // Amp select 0 keeps the internal amp up with resistors in series.
      next_st.out_amp_on = ~st.amp_select;
      next_st.out_fb_parallel = st.amp_select;
      next_st.out_clamp = st.ground_clamp;
      next_st.out_tri = st.ground_clamp | st.output_tristate;
   end

   // State register; the reset pin holds everything at its power-on values.
   always_ff @(posedge mclk) begin
      if (reset | (ce & ~rst_pin_n_s)) begin
         st <= '{phase: DMC_PH_IDLE, sync_n_prev: 1'b1, sclk_prev: 1'b0,
            bit_count: 5'h00, shift_in: 24'h000000, shift_out: 24'h000000,
            readback: 24'h000000, code: DMC_CODE_RESET, amp_select: DMC_AMP_RESET,
            ground_clamp: DMC_CLAMP_RESET, output_tristate: DMC_TRI_RESET,
            code_format: DMC_FMT_RESET, serial_out_disable: DMC_SOD_RESET,
            lin_comp: DMC_LIN_RESET, ser_bit: 1'b0, ser_oe: 1'b0,
            out_amp_on: ~DMC_AMP_RESET, out_fb_parallel: DMC_AMP_RESET,
            out_clamp: DMC_CLAMP_RESET, out_tri: 1'b1};
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign serial_data_out = st.ser_bit;
   assign serial_data_out_oe = st.ser_oe;
   assign output_code = st.code;
   assign internal_amp_on = st.out_amp_on;
   assign feedback_parallel = st.out_fb_parallel;
   assign ground_clamp_on = st.out_clamp;
   assign dac_tristated = st.out_tri;
   assign code_format = st.code_format;
   assign lin_comp = st.lin_comp;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   a_code_write: assert property (@(posedge mclk) disable iff (reset)
      ce && rst_pin_n_s && wr_code |=> output_code == $past(st.shift_in[19:0]))
      else $error("output code not loaded by write frame");

   a_ctrl_write: assert property (@(posedge mclk) disable iff (reset)
      ce && rst_pin_n_s && wr_ctrl |=> st.lin_comp == $past(st.shift_in[9:6])
      && st.serial_out_disable == $past(st.shift_in[5]))
      else $error("mode fields not loaded by write frame");

   // Derived outputs follow the fields one registered cycle later.
   a_amp_zero: assert property (@(posedge mclk) disable iff (reset)
      ce && rst_pin_n_s && !st.amp_select |=> internal_amp_on && !feedback_parallel)
      else $error("amp select zero not reflected");

   a_amp_one: assert property (@(posedge mclk) disable iff (reset)
      ce && rst_pin_n_s && st.amp_select |=> !internal_amp_on && feedback_parallel)
      else $error("amp select one not reflected");

   a_clamp_off: assert property (@(posedge mclk) disable iff (reset)
      ce && rst_pin_n_s && !st.ground_clamp && !st.output_tristate
      |=> !ground_clamp_on && !dac_tristated)
      else $error("clamp not removed");

   a_clamp_over_tri: assert property (@(posedge mclk) disable iff (reset)
      ce && rst_pin_n_s && st.ground_clamp |=> ground_clamp_on && dac_tristated)
      else $error("clamp did not force tristate");

   a_reset_clamp: assert property (@(posedge mclk)
      reset |=> st.ground_clamp && st.output_tristate && ground_clamp_on && dac_tristated)
      else $error("reset did not clamp output");

   a_read_no_write: assert property (@(posedge mclk) disable iff (reset)
      ce && rst_pin_n_s && rd_any |=> $stable(output_code) && $stable(st.lin_comp))
      else $error("read frame changed a register");

   // The disable bit only changes as a frame ends, so it never meets a driven pin.
   a_readback_disable: assert property (@(posedge mclk) disable iff (reset)
      st.serial_out_disable |-> !serial_data_out_oe)
      else $error("serial output driven while disabled");

   a_ctrl_readback: assert property (@(posedge mclk) disable iff (reset)
      ce && rst_pin_n_s && rd_any && op_addr == DMC_ADDR_CTRL
      |=> st.readback[9:1] == $past({st.lin_comp, st.serial_out_disable, st.code_format,
      st.output_tristate, st.ground_clamp, st.amp_select})
      && st.readback[19:10] == 10'h000 && st.readback[0] == 1'b0)
      else $error("mode readback word wrong");

endmodule : dmc_regmap

`default_nettype wire

/* File: hdl/dmc_pkg.sv */
// Constants shared by the converter register-map control block.
// Assumes a 24-bit serial frame: operation bit, three address bits, twenty data bits.
package dmc_pkg;

   // ***************************************************************
   // Frame layout
   // ***************************************************************
   localparam int DMC_FRAME_BITS = 24;
   localparam int DMC_DATA_BITS = 20;
   localparam int DMC_OP_POS = 23;
   localparam int DMC_ADDR_HI = 22;
   localparam int DMC_ADDR_LO = 20;
   localparam logic [4:0] DMC_FRAME_COUNT = 5'h18;
   localparam logic [4:0] DMC_COUNT_SAT = 5'h19;

   // ***************************************************************
   // Register addresses and operation codes
   // ***************************************************************
   localparam logic [2:0] DMC_ADDR_NOP = 3'h0;
   localparam logic [2:0] DMC_ADDR_CODE = 3'h1;
   localparam logic [2:0] DMC_ADDR_CTRL = 3'h2;
   localparam logic DMC_OP_WRITE = 1'h0;
   localparam logic DMC_OP_READ = 1'h1;

   // ***************************************************************
   // Mode control field positions
   // ***************************************************************
   localparam int DMC_AMP_POS = 1;
   localparam int DMC_CLAMP_POS = 2;
   localparam int DMC_TRI_POS = 3;
   localparam int DMC_FMT_POS = 4;
   localparam int DMC_SOD_POS = 5;
   localparam int DMC_LIN_LO = 6;
   localparam int DMC_LIN_HI = 9;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [19:0] DMC_CODE_RESET = 20'h00000;
   localparam logic DMC_AMP_RESET = 1'h0;
   localparam logic DMC_CLAMP_RESET = 1'h1;
   localparam logic DMC_TRI_RESET = 1'h1;
   localparam logic DMC_FMT_RESET = 1'h0;
   localparam logic DMC_SOD_RESET = 1'h0;
   localparam logic [3:0] DMC_LIN_RESET = 4'h0;

   // Frame phase of the serial port.
   typedef enum logic {
      DMC_PH_IDLE,
      DMC_PH_FRAME
   } dmc_phase_e;

endpackage : dmc_pkg

/* File: hdl/dmc_pin_sync.sv */
// Three-stage synchroniser for one pin sampled on mclk.
// Assumes the pin is asynchronous to mclk and changes much slower than mclk.
`timescale 1ns/10ps
`default_nettype none

module dmc_pin_sync #(
   parameter logic INIT = 1'h0
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic pin,
   output logic level
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic out;
   } dmc_sync_s;

   dmc_sync_s st;
   dmc_sync_s next_st;

   // ***************************************************************
   // Stages
   // ***************************************************************
   // The filtered level only moves when the second and third stages agree,
   // which costs a cycle of latency but rejects a single metastable sample.
   always_comb begin
      next_st = st;
      next_st.s1 = pin;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if (st.s2 == st.s3) begin
         next_st.out = st.s3;
      end
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge mclk) begin
      if (reset) begin
         st <= '{s1: INIT, s2: INIT, s3: INIT, out: INIT};
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign level = st.out;

endmodule : dmc_pin_sync

`default_nettype wire

/* File: tb/dmc_host_model.sv */
// Host controller model that drives the three-wire serial port of the converter.
// Assumes frame() is called from one process only, just after a falling mclk edge.
`timescale 1ns/10ps
`default_nettype none

module dmc_host_model (
   input wire logic mclk,
   input wire logic data_back,
   output logic sync_n,
   output logic sclk,
   output logic sdin
);
   // Idle levels at time zero: port deselected and serial clock parked low.
   initial begin
      sync_n = 1'h1;
      sclk = 1'h0;
      sdin = 1'h0;
   end

   // ******************************************************************
   // One frame: word MSB first, nfall clock falls, each level held hold cycles
   // ******************************************************************
   // A large hold models a slow host; a wrong nfall models a broken frame.
   task automatic frame(input logic [23:0] word, input int nfall, input int hold,
                        output logic [23:0] rd);
      rd = 24'h000000;
      sync_n = 1'h0;
      repeat (hold) @(negedge mclk);
      for (int i = 0; i < nfall; i++) begin
         sclk = 1'h1;
         sdin = (i < 24) ? word[23 - i] : 1'h0;
         repeat (hold) @(negedge mclk);
         if (i < 24) rd[23 - i] = data_back; // Sampled at our own falling clock edge.
         sclk = 1'h0;
         repeat (hold) @(negedge mclk);
      end
      sync_n = 1'h1;
      sdin = ~sdin; // A released line must not keep showing its last bit.
      repeat (hold) @(negedge mclk);
   endtask : frame
endmodule : dmc_host_model
`default_nettype wire

/* File: tb/test_dmc_regmap.sv */
// Self-checking bench of the converter register-map block.
// Assumes the host model in dmc_host_model.sv and the design package dmc_pkg.
`timescale 1ns/10ps
`default_nettype none

module test_dmc_regmap;
   import dmc_pkg::*;
   logic mclk = 1'h0;
   logic reset = 1'h1;
   logic ce = 1'h1;
   logic reset_pin_n = 1'h1;
   logic sync_n, sclk, sdin, readback_line, serial_data_out, serial_data_out_oe;
   logic [19:0] output_code;
   logic internal_amp_on, feedback_parallel, ground_clamp_on, dac_tristated, code_format;
   logic [3:0] lin_comp;
   logic [23:0] rd;
   int error_cnt = 0;
   int checks_done = 0;

   // Free-running 50 MHz clock.
   always #10 mclk = ~mclk;

   // The readback line floats whenever the block does not drive it.
   assign readback_line = serial_data_out_oe ? serial_data_out : 1'bz;

   dmc_regmap dut (.mclk(mclk), .reset(reset), .ce(ce), .sync_n(sync_n), .sclk(sclk),
      .sdin(sdin), .reset_pin_n(reset_pin_n), .serial_data_out(serial_data_out),
      .serial_data_out_oe(serial_data_out_oe), .output_code(output_code),
      .internal_amp_on(internal_amp_on), .feedback_parallel(feedback_parallel),
      .ground_clamp_on(ground_clamp_on), .dac_tristated(dac_tristated),
      .code_format(code_format), .lin_comp(lin_comp));

   dmc_host_model host (.mclk(mclk), .data_back(readback_line), .sync_n(sync_n), .sclk(sclk),
      .sdin(sdin));

   // ******************************************************************
   // Shared helpers
   // ******************************************************************
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Write frame, then let the derived outputs settle.
   task automatic wr(input logic [2:0] addr, input logic [19:0] data, input int hold);
      host.frame({DMC_OP_WRITE, addr, data}, 24, hold, rd);
      repeat (4) @(negedge mclk);
   endtask : wr

   // Read command followed by a no-operation frame that carries the answer out.
   task automatic rdreg(input logic [2:0] addr, output logic [23:0] word);
      host.frame({DMC_OP_READ, addr, 20'h00000}, 24, 6, rd);
      host.frame({DMC_OP_WRITE, DMC_ADDR_NOP, 20'h00000}, 24, 6, word);
   endtask : rdreg

   // ******************************************************************
   // Scenarios
   // ******************************************************************
   task automatic test_defaults;
      chk(24'(output_code), 24'h000000);
      chk(24'({ground_clamp_on, dac_tristated}), 24'h000003);
      chk(24'({internal_amp_on, feedback_parallel}), 24'h000002);
      chk(24'({code_format, lin_comp, serial_data_out_oe}), 24'h000000);
      $display("test defaults done");
   endtask : test_defaults

   // A mixed code and one with both field end bits set, the second with a slow host.
   task automatic test_code;
      logic [19:0] codes [2] = '{20'habcde, 20'h80001};
      logic [23:0] word;
      for (int i = 0; i < 2; i++) begin
         wr(DMC_ADDR_CODE, codes[i], 6 + 6 * i);
         chk(24'(output_code), 24'(codes[i]));
         rdreg(DMC_ADDR_CODE, word);
         chk(word, {DMC_OP_READ, DMC_ADDR_CODE, codes[i]});
      end
      $display("test code done");
   endtask : test_code

   // Host keeps unused bits zero in every word of this table.
   task automatic test_mode;
      logic [19:0] w [4] = '{20'h00006, 20'h00008, 20'h00000, 20'h003d2};
      logic [23:0] word;
      for (int i = 0; i < 4; i++) begin
         wr(DMC_ADDR_CTRL, w[i], 6);
         chk(24'({internal_amp_on, feedback_parallel}), 24'({~w[i][1], w[i][1]}));
         chk(24'(ground_clamp_on), 24'(w[i][2]));
         chk(24'(dac_tristated), 24'(w[i][2] | w[i][3]));
         chk(24'({code_format, lin_comp}), 24'({w[i][4], w[i][9:6]}));
         rdreg(DMC_ADDR_CTRL, word);
         chk(word, {DMC_OP_READ, DMC_ADDR_CTRL, w[i]});
      end
      $display("test mode done");
   endtask : test_mode

   // Short, long, no-operation and unmapped frames must leave the code alone.
   task automatic test_refuse;
      wr(DMC_ADDR_CODE, 20'h12345, 6);
      host.frame({DMC_OP_WRITE, DMC_ADDR_NOP, 20'h54321}, 24, 6, rd);
      host.frame({DMC_OP_WRITE, DMC_ADDR_CODE, 20'h54321}, 23, 6, rd);
      host.frame({DMC_OP_WRITE, DMC_ADDR_CODE, 20'h54321}, 25, 6, rd);
      host.frame({DMC_OP_WRITE, 3'h5, 20'h54321}, 24, 6, rd);
      repeat (4) @(negedge mclk);
      chk(24'(output_code), 24'h012345);
      $display("test refuse done");
   endtask : test_refuse

   task automatic test_sod;
      logic [23:0] word;
      wr(DMC_ADDR_CTRL, 20'h00020, 6);
      rdreg(DMC_ADDR_CTRL, word);
      chk(word, 24'hzzzzzz);
      wr(DMC_ADDR_CTRL, 20'h00000, 6);
      rdreg(DMC_ADDR_CTRL, word);
      chk(word, {DMC_OP_READ, DMC_ADDR_CTRL, 20'h00000});
      $display("test serial out done");
   endtask : test_sod

   // A frame sent while the clock enable is low must leave no trace.
   task automatic test_ce;
      wr(DMC_ADDR_CODE, 20'h0f0f0, 6);
      ce = 1'h0;
      host.frame({DMC_OP_WRITE, DMC_ADDR_CODE, 20'ha5a5a}, 24, 6, rd);
      ce = 1'h1;
      repeat (8) @(negedge mclk);
      chk(24'(output_code), 24'h00f0f0);
      $display("test clock enable done");
   endtask : test_ce

   // The hardware reset pin must restore the clamped, tristated state.
   task automatic test_pin;
      wr(DMC_ADDR_CODE, 20'h55555, 6);
      reset_pin_n = 1'h0;
      repeat (10) @(negedge mclk);
      reset_pin_n = 1'h1;
      repeat (8) @(negedge mclk);
      chk(24'({ground_clamp_on, dac_tristated, internal_amp_on}), 24'h000007);
      chk(24'(output_code), 24'h000000);
      $display("test reset pin done");
   endtask : test_pin

   // ******************************************************************
   // Verdict and run control
   // ******************************************************************
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude

   // Main sequence; reset is released at a falling edge after 20 cycles.
   initial begin
      repeat (20) @(negedge mclk);
      reset = 1'h0;
      repeat (8) @(negedge mclk);
      test_defaults();
      test_code();
      test_mode();
      test_refuse();
      test_sod();
      test_ce();
      test_pin();
      conclude();
   end

   // The tests need about 10000 cycles; this limit leaves ample margin.
   initial begin
      #(60000 * 20);
      error_cnt++;
      conclude();
   end
endmodule : test_dmc_regmap
`default_nettype wire
